// ===== logic/add_shift_bit_branch_exec.sv
/*
 * execute stage for add, add with carry, arithmetic shift right, bit
 * clear, bit test with skip and relative jump. holds the accumulator,
 * the carry, nibble overflow and zero flags and the file registers.
 * assumes: fetch presents one decoded instruction per cycle with the
 * address of that instruction; an instruction offered during the nop
 * cycle is the one being discarded; fetch follows pc_load_o; the rest
 * of the core writes file registers through the load port.
 */
`timescale 1ns/1ns

// Summary of operation
// - add accumulator and register, choose destination, flags
// - same add plus carry flag in
// - shift right, keep sign, low bit to carry
// - clear selected bit, flags untouched
// - skip next instruction when tested bit low
// - jump target is address plus one plus offset
// - relative jump always takes two cycles
// - pc change or true test adds nop cycle
module add_shift_bit_branch_exec #(
	parameter int PC_W = exec_pkg::PC_W  // program counter width
) (
	// clock and reset
	input  wire logic                            clk_i,
	input  wire logic                            rst_i,
	// decoded instruction from fetch
	input  wire logic                            instr_valid_i,
	input  wire exec_pkg::op_t                   op_i,
	input  wire logic [exec_pkg::FADDR_W-1:0]    faddr_i,
	input  wire logic                            dest_i,
	input  wire logic [exec_pkg::BIT_W-1:0]      bitsel_i,
	input  wire logic [exec_pkg::OFS_W-1:0]      offset_i,
	input  wire logic [PC_W-1:0]                 pc_i,
	// file register load port, used by the rest of the core
	input  wire logic                            load_en_i,
	input  wire logic [exec_pkg::FADDR_W-1:0]    load_addr_i,
	input  wire logic [exec_pkg::DATA_W-1:0]     load_data_i,
	// file register observation port
	input  wire logic [exec_pkg::FADDR_W-1:0]    peek_addr_i,
	output logic      [exec_pkg::DATA_W-1:0]     peek_data_o,
	// core state
	output logic      [exec_pkg::DATA_W-1:0]     acc_o,
	output logic                                 carry_o,
	output logic                                 nibble_overflow_o,
	output logic                                 zero_o,
	// program counter control
	output logic                                 pc_load_o,
	output logic      [PC_W-1:0]                 pc_target_o,
	output logic                                 nop_cycle_o
);
	import exec_pkg::*;

	// ----------------------------------------------------------------
	// storage and wires
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] file_mem [FILE_DEPTH];  // file registers
	logic [DATA_W-1:0] acc_reg;                // accumulator
	logic              carry_reg;              // carry flag
	logic              nibble_reg;             // nibble overflow flag
	logic              zero_reg;               // zero flag
	phase_t            phase_reg;              // exec or nop cycle
	phase_t            phase_next;
	logic              pc_load_reg;            // jump strobe
	logic [PC_W-1:0]   target_reg;             // jump target
	logic [PC_W-1:0]   target_next;
	logic [DATA_W-1:0] peek_reg;               // observed register
	logic [DATA_W-1:0] freg;                   // operand read
	logic [DATA_W-1:0] alu_res;
	logic              alu_c;
	logic              alu_dc;
	logic              alu_z;
	logic              alu_low;
	logic              exec;                   // instruction executes
	logic              is_arith;               // add, add with carry or shift
	logic              take_nop;               // second cycle needed

	assign freg  = file_mem[faddr_i];
	assign exec  = instr_valid_i && (phase_reg == ST_EXEC);
	assign is_arith = (op_i == OP_ADD_ACC_REG)
		|| (op_i == OP_ADD_ACC_REG_CARRY)
		|| (op_i == OP_ARITH_SHIFT_RIGHT);
	// taken skip or any jump costs a nop cycle
	assign take_nop = (op_i == OP_RELATIVE_JUMP)
		|| ((op_i == OP_SKIP_IF_BIT_LOW) && alu_low);
	// signed offset onto the instruction address plus one
	assign target_next = pc_i + PC_STEP
		+ {{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i};

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	shift_add_alu u_alu (
		.op_i      (op_i),
		.acc_i     (acc_reg),
		.freg_i    (freg),
		.carry_i   (carry_reg),
		.bitsel_i  (bitsel_i),
		.result_o  (alu_res),
		.carry_o   (alu_c),
		.nibble_o  (alu_dc),
		.zero_o    (alu_z),
		.bit_low_o (alu_low)
	);

	// ----------------------------------------------------------------
	// phase control
	// ----------------------------------------------------------------
	// the nop cycle drops whatever fetch offers, then returns to exec
	always_comb begin
		case (phase_reg)
			ST_EXEC: phase_next = (exec && take_nop) ? ST_NOP : ST_EXEC;
			ST_NOP:  phase_next = ST_EXEC;
			default: phase_next = ST_EXEC;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_reg <= ST_EXEC;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// jump strobe and target, one cycle after the jump executes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_load_reg <= 1'b0;
			target_reg  <= '0;
		end else begin
			pc_load_reg <= exec && (op_i == OP_RELATIVE_JUMP);
			if (exec && (op_i == OP_RELATIVE_JUMP)) begin
				target_reg <= target_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// accumulator and flags
	// ----------------------------------------------------------------
	// only the arithmetic group touches these
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_reg    <= ACC_RST;
			carry_reg  <= FLAG_RST;
			nibble_reg <= FLAG_RST;
			zero_reg   <= FLAG_RST;
		end else if (exec && is_arith) begin
			if (dest_i == DEST_ACC) begin
				acc_reg <= alu_res;
			end
			carry_reg <= alu_c;
			zero_reg  <= alu_z;
			// shift leaves nibble overflow alone
			if (op_i != OP_ARITH_SHIFT_RIGHT) begin
				nibble_reg <= alu_dc;
			end
		end
	end

	// ----------------------------------------------------------------
	// file registers
	// ----------------------------------------------------------------
	// no reset on the array; an executing result wins over a load,
	// the core never issues both in one cycle
	always_ff @(posedge clk_i) begin
		if (exec && ((is_arith && (dest_i == DEST_REG))
			|| (op_i == OP_BIT_CLEAR))) begin
			file_mem[faddr_i] <= alu_res;
		end else if (load_en_i) begin
			file_mem[load_addr_i] <= load_data_i;
		end
	end

	// registered observation read
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			peek_reg <= ACC_RST;
		end else begin
			peek_reg <= file_mem[peek_addr_i];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign acc_o             = acc_reg;
	assign carry_o           = carry_reg;
	assign nibble_overflow_o = nibble_reg;
	assign zero_o            = zero_reg;
	assign pc_load_o         = pc_load_reg;
	assign pc_target_o       = target_reg;
	assign peek_data_o       = peek_reg;
	assign nop_cycle_o       = (phase_reg == ST_NOP);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [DATA_W:0]    chk_sum;     // independent sum with carry in
	logic [NIB_MSB+1:0] chk_nib;     // independent low nibble sum
	logic               chk_cin;     // carry in of the checked add
	logic               chk_bit;     // tested bit of the operand
	logic [PC_W-1:0]    chk_target;  // address plus one plus offset
	assign chk_cin = (op_i == OP_ADD_ACC_REG_CARRY) & carry_reg;
	assign chk_sum = {1'b0, acc_reg} + {1'b0, freg}
		+ {{DATA_W{1'b0}}, chk_cin};
	assign chk_nib = {1'b0, acc_reg[NIB_MSB:0]} + {1'b0, freg[NIB_MSB:0]}
		+ {{(NIB_MSB+1){1'b0}}, chk_cin};
	assign chk_bit = freg[bitsel_i];
	// size cast of the signed offset sign-extends it
	assign chk_target = pc_i + PC_STEP + PC_W'($signed(offset_i));

	add_to_acc_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec && op_i == OP_ADD_ACC_REG && dest_i == DEST_ACC
		|=> acc_o == $past(chk_sum[DATA_W-1:0])
		&& carry_o == $past(chk_sum[DATA_W])
		&& nibble_overflow_o == $past(chk_nib[NIB_MSB+1]))
		else $error("add result or flags wrong");

	add_carry_in_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec && op_i == OP_ADD_ACC_REG_CARRY && dest_i == DEST_ACC
		|=> {carry_o, acc_o} == $past(chk_sum)
		&& zero_o == ($past(chk_sum[DATA_W-1:0]) == ACC_RST))
		else $error("add with carry result wrong");

	shift_right_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec && op_i == OP_ARITH_SHIFT_RIGHT && dest_i == DEST_ACC
		|=> acc_o == {$past(freg[SIGN_BIT]), $past(freg[SIGN_BIT:1])}
		&& carry_o == $past(freg[0]) && $stable(nibble_overflow_o))
		else $error("arithmetic shift wrong");

	bit_clear_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec && op_i == OP_BIT_CLEAR
		|=> file_mem[$past(faddr_i)][$past(bitsel_i)] == 1'b0
		&& $stable(carry_o) && $stable(zero_o) && $stable(acc_o))
		else $error("bit clear wrong or flags changed");

	// a nop cycle after the skip must end after one cycle; a later
	// instruction may start its own nop cycle
	skip_taken_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec && op_i == OP_SKIP_IF_BIT_LOW
		|=> nop_cycle_o == !$past(chk_bit)
		##1 !($past(nop_cycle_o) && nop_cycle_o))
		else $error("skip decision wrong");

	jump_target_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec && op_i == OP_RELATIVE_JUMP
		|=> pc_load_o && pc_target_o == $past(chk_target))
		else $error("jump target wrong");

	jump_two_cycle_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec && op_i == OP_RELATIVE_JUMP
		|=> nop_cycle_o ##1 (!nop_cycle_o && !pc_load_o))
		else $error("jump not two cycles");

	nop_cycle_quiet_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		nop_cycle_o |=> $stable(acc_o) && $stable(carry_o)
		&& $stable(zero_o) && $stable(nibble_overflow_o))
		else $error("nop cycle changed state");

endmodule

// ===== logic/exec_pkg.sv
/*
 * shared constants and types for the instruction execution slice:
 * operand widths, reset values, destination codes, operation codes.
 * assumes: included before every file that names exec_pkg.
 */
package exec_pkg;

	// ----------------------------------------------------------------
	// operand widths
	// ----------------------------------------------------------------
	localparam int DATA_W  = 8;            // data word width
	localparam int FADDR_W = 7;            // file register address width
	localparam int BIT_W   = 3;            // bit index width
	localparam int OFS_W   = 9;            // signed jump offset width
	localparam int PC_W    = 15;           // program counter width
	localparam int FILE_DEPTH = 128;       // number of file registers

	// ----------------------------------------------------------------
	// field positions and fixed values
	// ----------------------------------------------------------------
	localparam int NIB_MSB  = 3;           // top bit of the low nibble
	localparam int SIGN_BIT = 7;           // sign bit of a data word
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;  // accumulator reset
	localparam logic              FLAG_RST = 1'b0;   // flag reset value
	localparam logic              DEST_ACC = 1'b0;   // result to accumulator
	localparam logic              DEST_REG = 1'b1;   // result to register
	localparam logic [PC_W-1:0]   PC_STEP  = 15'h0001; // pc increment

	// ----------------------------------------------------------------
	// operations this slice executes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP,
		OP_ADD_ACC_REG,
		OP_ADD_ACC_REG_CARRY,
		OP_ARITH_SHIFT_RIGHT,
		OP_BIT_CLEAR,
		OP_SKIP_IF_BIT_LOW,
		OP_RELATIVE_JUMP
	} op_t;

	// execution phase
	typedef enum logic {
		ST_EXEC,
		ST_NOP
	} phase_t;

endpackage

// ===== logic/shift_add_alu.sv
/*
 * combinational datapath: add, add with carry, arithmetic shift right,
 * bit clear and bit test, with the flag results of each.
 * assumes: operands are stable for the cycle; the caller decides where
 * results go and whether flags are written.
 */
`timescale 1ns/1ns
module shift_add_alu (
	// operation and operands
	input  wire exec_pkg::op_t                   op_i,
	input  wire logic [exec_pkg::DATA_W-1:0]     acc_i,
	input  wire logic [exec_pkg::DATA_W-1:0]     freg_i,
	input  wire logic                            carry_i,
	input  wire logic [exec_pkg::BIT_W-1:0]      bitsel_i,
	// results
	output logic      [exec_pkg::DATA_W-1:0]     result_o,
	output logic                                 carry_o,
	output logic                                 nibble_o,
	output logic                                 zero_o,
	output logic                                 bit_low_o
);
	import exec_pkg::*;

	logic [DATA_W:0]    sum;     // full sum with carry out
	logic [NIB_MSB+1:0] nib_sum; // low nibble sum with its carry out
	logic               cin;     // carry in for the adder

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	always_comb begin
		cin      = (op_i == OP_ADD_ACC_REG_CARRY) ? carry_i : 1'b0;
		sum      = {1'b0, acc_i} + {1'b0, freg_i} + {{DATA_W{1'b0}}, cin};
		nib_sum  = {1'b0, acc_i[NIB_MSB:0]} + {1'b0, freg_i[NIB_MSB:0]}
			+ {{(NIB_MSB+1){1'b0}}, cin};
		result_o = freg_i;
		carry_o  = carry_i;
		nibble_o = 1'b0;
		bit_low_o = ~freg_i[bitsel_i];
		case (op_i)
			// plain add and add with carry share the adder
			OP_ADD_ACC_REG, OP_ADD_ACC_REG_CARRY: begin
				result_o = sum[DATA_W-1:0];
				carry_o  = sum[DATA_W];
				nibble_o = nib_sum[NIB_MSB+1];
			end
			// sign bit kept, low bit falls into carry
			OP_ARITH_SHIFT_RIGHT: begin
				result_o = {freg_i[SIGN_BIT], freg_i[SIGN_BIT:1]};
				carry_o  = freg_i[0];
			end
			// clear only the selected bit
			OP_BIT_CLEAR: begin
				result_o = freg_i & ~(8'h01 << bitsel_i);
			end
			default: begin
				result_o = freg_i;
			end
		endcase
		zero_o = (result_o == ACC_RST);
	end

endmodule

// ===== dv/add_shift_bit_branch_exec_bench.sv
/*
 * self-checking bench for the execute stage: bit clear, add, add with
 * carry, shift, skip on low bit and relative jump, with nop cycles.
 * assumes: exec_pkg is compiled first; file registers start unknown, so
 * a register is cleared bit by bit before its value is relied on.
 */
`timescale 1ns/1ns
module add_shift_bit_branch_exec_bench;
	import exec_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                clk_i;          // core clock
	logic                rst_i;          // async reset, high
	logic                instr_valid_i;  // instruction offered
	op_t                 op_i;           // operation
	logic [FADDR_W-1:0]  faddr_i;        // file register address
	logic                dest_i;         // destination select
	logic [BIT_W-1:0]    bitsel_i;       // bit index
	logic [OFS_W-1:0]    offset_i;       // jump offset
	logic [PC_W-1:0]     pc_i;           // instruction address
	logic                load_en_i;      // file register load strobe
	logic [FADDR_W-1:0]  load_addr_i;    // loaded register
	logic [DATA_W-1:0]   load_data_i;    // loaded value
	logic [FADDR_W-1:0]  peek_addr_i;    // observed register
	logic [DATA_W-1:0]   peek_data_o;    // observed value
	logic [DATA_W-1:0]   acc_o;          // accumulator
	logic                carry_o;        // carry flag
	logic                nibble_overflow_o; // nibble carry flag
	logic                zero_o;         // zero flag
	logic                pc_load_o;      // pc load pulse
	logic [PC_W-1:0]     pc_target_o;    // jump target
	logic                nop_cycle_o;    // discard cycle
	int                  n_errors;       // mismatches
	int                  total_checks;   // comparisons
	int                  cycles;         // timeout counter

	// one comparison, counted, reported at once on mismatch
	`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin \
		n_errors++; $display("wrong value at %0t: %s", $time, m); end end

	add_shift_bit_branch_exec #(.PC_W(PC_W)) add_shift_bit_branch_exec_inst (
		.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
		.op_i(op_i), .faddr_i(faddr_i), .dest_i(dest_i),
		.bitsel_i(bitsel_i), .offset_i(offset_i), .pc_i(pc_i),
		.load_en_i(load_en_i), .load_addr_i(load_addr_i),
		.load_data_i(load_data_i),
		.peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o),
		.acc_o(acc_o), .carry_o(carry_o),
		.nibble_overflow_o(nibble_overflow_o), .zero_o(zero_o),
		.pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
		.nop_cycle_o(nop_cycle_o));

	// ------------------------------------------------------------
	// clock, timeout and closing report
	// ------------------------------------------------------------
	// free running 100 MHz clock
	always #5 clk_i = ~clk_i;

	// cut a hang short after far more cycles than the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			$display("wrong value at %0t: timeout", $time);
			results();
		end
	end

	// counts, verdict, end of run
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// drivers: inputs change 1 ns after the rising edge
	// ------------------------------------------------------------
	// offer one instruction, return just after the taking edge
	task automatic put(op_t op, logic [FADDR_W-1:0] fa, logic d,
		logic [BIT_W-1:0] b, logic [OFS_W-1:0] ofs, logic [PC_W-1:0] pc);
		load_en_i = 1'b0;
		instr_valid_i = 1'b1;
		op_i = op;
		faddr_i = fa;
		dest_i = d;
		bitsel_i = b;
		offset_i = ofs;
		pc_i = pc;
		@(posedge clk_i);
		#1;
	endtask

	// no instruction for one cycle
	task automatic idle();
		load_en_i = 1'b0;
		instr_valid_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	// write a file register as the rest of the core would
	task automatic load(logic [FADDR_W-1:0] fa, logic [DATA_W-1:0] d);
		instr_valid_i = 1'b0;
		load_en_i = 1'b1;
		load_addr_i = fa;
		load_data_i = d;
		@(posedge clk_i);
		#1;
	endtask

	// read a file register through the peek port
	task automatic peek(logic [FADDR_W-1:0] fa, logic [DATA_W-1:0] exp);
		peek_addr_i = fa;
		idle();
		idle();
		`CHK(peek_data_o, exp, "file register content")
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// clear every bit of a register; flags stay as they were
	task automatic t_clear();
		for (int b = 0; b < 8; b++)
			put(OP_BIT_CLEAR, 7'h05, DEST_REG, b[2:0], 9'h000, 15'h0000);
		`CHK(zero_o, 1'b0, "flags after bit clear")
		peek(7'h05, 8'h00);
		$display("test clear done");
	endtask

	// loaded operands through add to acc, add with carry to register, shift both ways
	task automatic t_arith();
		load(7'h06, 8'h8e);
		put(OP_ADD_ACC_REG, 7'h06, DEST_ACC, 3'h0, 9'h000, 15'h0000);
		`CHK(acc_o, 8'h8e, "sum in accumulator")
		`CHK(zero_o, 1'b0, "zero flag after add")
		put(OP_ADD_ACC_REG, 7'h06, DEST_ACC, 3'h0, 9'h000, 15'h0000);
		`CHK(acc_o, 8'h1c, "sum wraps")
		`CHK(carry_o, 1'b1, "carry after add")
		`CHK(nibble_overflow_o, 1'b1, "nibble flag after add")
		put(OP_ADD_ACC_REG_CARRY, 7'h06, DEST_REG, 3'h0, 9'h000, 15'h0);
		`CHK(acc_o, 8'h1c, "register destination kept acc")
		`CHK(carry_o, 1'b0, "carry after add carry")
		`CHK(nibble_overflow_o, 1'b1, "nibble after add carry")
		peek(7'h06, 8'hab);
		put(OP_ARITH_SHIFT_RIGHT, 7'h06, DEST_ACC, 3'h0, 9'h000, 15'h0);
		`CHK(acc_o, 8'hd5, "shift keeps sign bit")
		`CHK(carry_o, 1'b1, "shift low bit to carry")
		`CHK(zero_o, 1'b0, "zero flag after shift")
		put(OP_ARITH_SHIFT_RIGHT, 7'h06, DEST_REG, 3'h0, 9'h000, 15'h0);
		peek(7'h06, 8'hd5);
		load(7'h05, 8'h2b);
		put(OP_ADD_ACC_REG, 7'h05, DEST_ACC, 3'h0, 9'h000, 15'h0000);
		`CHK(acc_o, 8'h00, "sum to zero")
		`CHK(zero_o, 1'b1, "zero flag on zero sum")
		`CHK(carry_o, 1'b1, "carry on zero sum")
		put(OP_BIT_CLEAR, 7'h05, DEST_REG, 3'h0, 9'h000, 15'h0000);
		`CHK(zero_o, 1'b1, "bit clear kept zero flag")
		`CHK(carry_o, 1'b1, "bit clear kept carry")
		peek(7'h05, 8'h2a);
		$display("test arith done");
	endtask

	// set bit runs on; low bit: one discard cycle, offered jump ignored
	task automatic t_skip();
		put(OP_SKIP_IF_BIT_LOW, 7'h05, DEST_ACC, 3'h3, 9'h000, 15'h0);
		`CHK(nop_cycle_o, 1'b0, "set bit does not skip")
		`CHK(pc_load_o, 1'b0, "test does not load pc")
		put(OP_SKIP_IF_BIT_LOW, 7'h05, DEST_ACC, 3'h4, 9'h000, 15'h0);
		`CHK(nop_cycle_o, 1'b1, "skip discard cycle")
		`CHK(pc_load_o, 1'b0, "skip does not load pc")
		put(OP_RELATIVE_JUMP, 7'h00, DEST_ACC, 3'h0, 9'h010, 15'h0040);
		`CHK(nop_cycle_o, 1'b0, "discard lasts one cycle")
		`CHK(pc_load_o, 1'b0, "discarded jump ignored")
		`CHK(zero_o, 1'b1, "skip kept flags")
		idle();
		$display("test skip done");
	endtask

	// jumps at offset and address boundaries, back to back
	task automatic t_jump();
		logic [PC_W-1:0]  pcs  [4] = '{15'h0064, 15'h012c, 15'h0000,
			15'h7fff};
		logic [OFS_W-1:0] ofss [4] = '{9'h0ff, 9'h100, 9'h000, 9'h001};
		// address plus one plus signed offset, wrapping at the top
		logic [PC_W-1:0]  exps [4] = '{15'h0164, 15'h002d, 15'h0001,
			15'h0001};
		for (int i = 0; i < 4; i++) begin
			put(OP_RELATIVE_JUMP, 7'h00, DEST_ACC, 3'h0, ofss[i], pcs[i]);
			`CHK(pc_load_o, 1'b1, "jump loads pc")
			`CHK(pc_target_o, exps[i], "jump target")
			`CHK(nop_cycle_o, 1'b1, "jump second cycle nop")
			`CHK(zero_o, 1'b1, "jump kept flags")
			put(OP_RELATIVE_JUMP, 7'h00, DEST_ACC, 3'h0, 9'h055, 15'h0);
			`CHK(pc_load_o, 1'b0, "load is one pulse")
			`CHK(pc_target_o, exps[i], "target holds")
			`CHK(nop_cycle_o, 1'b0, "nop lasts one cycle")
		end
		idle();
		$display("test jump done");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		instr_valid_i = 1'b0;
		op_i = OP_NOP;
		faddr_i = '0;
		dest_i = DEST_ACC;
		bitsel_i = '0;
		offset_i = '0;
		pc_i = '0;
		peek_addr_i = '0;
		load_en_i = 1'b0;
		load_addr_i = '0;
		load_data_i = '0;
		n_errors = 0;
		total_checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		`CHK(acc_o, ACC_RST, "accumulator reset")
		`CHK(nop_cycle_o, 1'b0, "no discard after reset")
		t_clear();
		t_arith();
		t_skip();
		t_jump();
		// reset in mid run returns flags to their reset value
		rst_i = 1'b1;
		idle();
		rst_i = 1'b0;
		`CHK(zero_o, FLAG_RST, "zero flag cleared by reset")
		`CHK(carry_o, FLAG_RST, "carry cleared by reset")
		`CHK(nibble_overflow_o, FLAG_RST, "nibble flag cleared by reset")
		`CHK(pc_target_o, '0, "jump target cleared by reset")
		results();
	end
endmodule
